// >>> logic/ssrw_defs.svh
`ifndef SSRW_DEFS_SVH
`define SSRW_DEFS_SVH
// Timing figures in their own units
`define SSRW_CLK_MHZ       200
`define SSRW_RESET_DLY_MS  200
`define SSRW_OV_DLY_US     25
`define SSRW_WD_INIT_MS    102400
`define SSRW_WD_NORM_MS    1600
`define SSRW_MR_REJECT_NS  100
// Derived cycle counts
`define SSRW_RESET_CYC  (`SSRW_RESET_DLY_MS * `SSRW_CLK_MHZ * 1000)
`define SSRW_OV_CYC     (`SSRW_OV_DLY_US * `SSRW_CLK_MHZ)
`define SSRW_WD_INIT_CYC (64'd`SSRW_WD_INIT_MS * 64'd`SSRW_CLK_MHZ * 64'd1000)
`define SSRW_WD_NORM_CYC (64'd`SSRW_WD_NORM_MS * 64'd`SSRW_CLK_MHZ * 64'd1000)
`define SSRW_MR_CYC     ((`SSRW_MR_REJECT_NS * `SSRW_CLK_MHZ + 999) / 1000 + 1)
`define SSRW_RAIL_CNT   6
`endif

// >>> logic/ssrw_pkg.sv
package ssrw_pkg;
  typedef enum logic [1:0] {
    SSRW_WD_INIT = 2'b01,
    SSRW_WD_NORM = 2'b10
  } ssrw_wd_mode_t;
endpackage

// >>> logic/ssrw_top.sv
`timescale 1ns/1ps
`include "ssrw_defs.svh"
module ssrw_top #(
  parameter int unsigned RAILS     = `SSRW_RAIL_CNT,
  parameter logic [31:0] RESET_CYC = 32'(`SSRW_RESET_CYC),
  parameter logic [31:0] OV_CYC    = 32'(`SSRW_OV_CYC),
  parameter logic [35:0] WD_INIT   = 36'(`SSRW_WD_INIT_CYC),
  parameter logic [35:0] WD_NORM   = 36'(`SSRW_WD_NORM_CYC),
  parameter logic [7:0]  MR_CYC    = 8'(`SSRW_MR_CYC)
) (
  input  wire logic             core_clk_in,
  input  wire logic             reset_n_in,
  input  wire logic [RAILS-1:0] rail_uv_in,
  input  wire logic [RAILS-1:0] rail_ov_in,
  input  wire logic [RAILS-1:0] rail_enable_in,
  input  wire logic             manual_reset_in_n,
  input  wire logic             margin_in_n,
  input  wire logic             watchdog_kick_in,
  output logic                  reset_out_n,
  output logic                  overvolt_flag_n,
  output logic                  watchdog_expired_n,
  output ssrw_pkg::ssrw_wd_mode_t wd_mode_out
);
  import ssrw_pkg::*;

  // ----------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Pins are asynchronous; first stage read only by the second
  logic [RAILS-1:0] uv_s1_q, uv_s2_q, ov_s1_q, ov_s2_q;
  logic [2:0]       ctl_s1_q, ctl_s2_q;
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      uv_s1_q  <= '1;
      uv_s2_q  <= '1;
      ov_s1_q  <= '0;
      ov_s2_q  <= '0;
      ctl_s1_q <= 3'h3;
      ctl_s2_q <= 3'h3;
    end else begin
      uv_s1_q  <= rail_uv_in & rail_enable_in;
      uv_s2_q  <= uv_s1_q;
      ov_s1_q  <= rail_ov_in & rail_enable_in;
      ov_s2_q  <= ov_s1_q;
      ctl_s1_q <= {watchdog_kick_in, margin_in_n, manual_reset_in_n};
      ctl_s2_q <= ctl_s1_q;
    end
  end

  logic any_uv, any_ov, mr_raw_n, hold, kick;
  assign any_uv   = |uv_s2_q;
  assign any_ov   = |ov_s2_q;
  assign mr_raw_n = ctl_s2_q[0];
  assign hold     = !ctl_s2_q[1];
  assign kick     = ctl_s2_q[2];

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  logic [7:0]    mr_cnt_q, mr_cnt_d;
  logic          mr_act_q, mr_act_d;
  logic [31:0]   rst_cnt_q, rst_cnt_d;
  logic [31:0]   ov_cnt_q, ov_cnt_d;
  logic [35:0]   wd_cnt_q, wd_cnt_d;
  logic          kick_q, kick_d;
  logic          rst_n_q, rst_n_d, ovf_n_q, ovf_n_d, wdo_n_q, wdo_n_d;
  ssrw_wd_mode_t mode_q, mode_d;
  logic          edge_seen;
  logic [35:0]   wd_lim;

  always_comb begin
    mr_cnt_d  = mr_cnt_q;
    mr_act_d  = mr_act_q;
    rst_cnt_d = rst_cnt_q;
    ov_cnt_d  = ov_cnt_q;
    wd_cnt_d  = wd_cnt_q;
    kick_d    = kick;
    rst_n_d   = rst_n_q;
    ovf_n_d   = ovf_n_q;
    wdo_n_d   = wdo_n_q;
    mode_d    = mode_q;
    edge_seen = kick != kick_q;
    case (mode_q)
      SSRW_WD_INIT: wd_lim = WD_INIT;
      SSRW_WD_NORM: wd_lim = WD_NORM;
      default:      wd_lim = WD_NORM;
    endcase
    // Short lows never reach the reset path
    if (mr_raw_n) begin
      mr_cnt_d = 8'h0;
      mr_act_d = 1'b0;
    end else if (mr_cnt_q >= MR_CYC) begin
      mr_act_d = 1'b1;
    end else begin
      mr_cnt_d = mr_cnt_q + 8'h1;
    end
    if (hold) begin
      // Outputs frozen; reset, OV and watchdog timers stand still so nothing jumps on release; MR filter cleared
      mr_act_d = 1'b0;
      mr_cnt_d = 8'h0;
    end else begin
      if (any_uv || mr_act_q) begin
        rst_n_d   = 1'b0;
        rst_cnt_d = 32'h0;
      end else if (!rst_n_q) begin
        if (rst_cnt_q >= RESET_CYC - 32'h1) begin
          rst_n_d = 1'b1;
        end else begin
          rst_cnt_d = rst_cnt_q + 32'h1;
        end
      end
      if (any_ov) begin
        ovf_n_d  = 1'b0;
        ov_cnt_d = 32'h0;
      end else if (!ovf_n_q) begin
        if (ov_cnt_q >= OV_CYC - 32'h1) begin
          ovf_n_d = 1'b1;
        end else begin
          ov_cnt_d = ov_cnt_q + 32'h1;
        end
      end
      if (edge_seen) begin
        wdo_n_d  = 1'b1;
        wd_cnt_d = 36'h0;
        mode_d   = SSRW_WD_NORM;
      end else if (wdo_n_q) begin
        if (wd_cnt_q >= wd_lim - 36'h1) begin
          wdo_n_d  = 1'b0;
          wd_cnt_d = 36'h0;
        end else begin
          wd_cnt_d = wd_cnt_q + 36'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      mr_cnt_q  <= 8'h0;
      mr_act_q  <= 1'b0;
      rst_cnt_q <= 32'h0;
      ov_cnt_q  <= 32'h0;
      wd_cnt_q  <= 36'h0;
      kick_q    <= 1'b0;
      rst_n_q   <= 1'b0;
      ovf_n_q   <= 1'b0;
      wdo_n_q   <= 1'b1;
      mode_q    <= SSRW_WD_INIT;
    end else begin
      mr_cnt_q  <= mr_cnt_d;
      mr_act_q  <= mr_act_d;
      rst_cnt_q <= rst_cnt_d;
      ov_cnt_q  <= ov_cnt_d;
      wd_cnt_q  <= wd_cnt_d;
      kick_q    <= kick_d;
      rst_n_q   <= rst_n_d;
      ovf_n_q   <= ovf_n_d;
      wdo_n_q   <= wdo_n_d;
      mode_q    <= mode_d;
    end
  end

  assign reset_out_n        = rst_n_q;
  assign overvolt_flag_n    = ovf_n_q;
  assign watchdog_expired_n = wdo_n_q;
  assign wd_mode_out        = mode_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_uv_asserts: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (!hold && any_uv) |=> !reset_out_n) else $error("uv no reset");
  chk_reset_hold: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    $rose(reset_out_n) |-> rst_cnt_q == RESET_CYC - 32'h1)
    else $error("reset released early");
  chk_ov_asserts: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (!hold && any_ov) |=> !overvolt_flag_n) else $error("ov missed");
  chk_ov_stretch: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    $rose(overvolt_flag_n) |-> ov_cnt_q == OV_CYC - 32'h1 && !$past(any_ov))
    else $error("ov released early");
  chk_wd_expire: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    $fell(watchdog_expired_n) |-> $past(wd_cnt_q) == $past(wd_lim) - 36'h1)
    else $error("watchdog period wrong");
  chk_kick_clears: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (!hold && edge_seen) |=> watchdog_expired_n && mode_q == SSRW_WD_NORM)
    else $error("kick ignored");
  chk_mr_glitch: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    $rose(mr_act_q) |-> $past(mr_cnt_q) >= MR_CYC)
    else $error("glitch accepted");
  chk_margin_frz: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    hold |=> $stable(reset_out_n) && $stable(overvolt_flag_n)
    && $stable(watchdog_expired_n)) else $error("output moved");
  chk_margin_mr: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    hold |=> !mr_act_q) else $error("mr during margin");
endmodule

// >>> bench/ssrw_host.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host side: kick toggler, reset button
// ----------------------------------------
module ssrw_host (
  input  wire logic clk_in,
  input  wire logic kick_en_in,
  input  wire logic mr_req_in,
  output logic      kick_out,
  output logic      mr_n_out
);
  logic [4:0] cnt_q;
  initial cnt_q = 5'h00;
  initial kick_out = 1'b0;
  initial mr_n_out = 1'b1;
  // Period 32 stays well inside the normal timeout
  always @(posedge clk_in) begin
    cnt_q <= cnt_q + 5'h01;
    if (kick_en_in && cnt_q == 5'h00) kick_out <= ~kick_out;
    mr_n_out <= ~mr_req_in;
  end
endmodule

// >>> bench/tb.sv
`timescale 1ns/1ps
// ----------------------------------------
// Bench top
// ----------------------------------------
module tb;
  import ssrw_pkg::*;
  logic          clk = 1'b0;
  logic          rst_n = 1'b0;
  logic          mg_n = 1'b1;
  logic          kick_en = 1'b0;
  logic          mr_req = 1'b0;
  logic [5:0]    uv = 6'h00;
  logic [5:0]    ov = 6'h00;
  logic [5:0]    en = 6'h3f;
  logic          kick, mr_n, rs_n, ov_n, wd_n;
  ssrw_wd_mode_t mode;
  int            fails = 0;
  int            check_count = 0;
  int            t;
  always #2.5 clk = ~clk;
  // Short counts keep the run small
  ssrw_top #(.RESET_CYC(32'd50), .OV_CYC(32'd10), .WD_INIT(36'd400),
    .WD_NORM(36'd100), .MR_CYC(8'd4)) i_ssrw_top (
    .core_clk_in(clk), .reset_n_in(rst_n), .rail_uv_in(uv),
    .rail_ov_in(ov), .rail_enable_in(en), .manual_reset_in_n(mr_n),
    .margin_in_n(mg_n), .watchdog_kick_in(kick), .reset_out_n(rs_n),
    .overvolt_flag_n(ov_n), .watchdog_expired_n(wd_n),
    .wd_mode_out(mode));
  ssrw_host i_ssrw_host (.clk_in(clk), .kick_en_in(kick_en),
    .mr_req_in(mr_req), .kick_out(kick), .mr_n_out(mr_n));
  // Sampling on falling edges avoids races with the design
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(string n, logic s, logic e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %b seen %b", n, e, s);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic t_power;
    for (t = 0; t < 90 && rs_n !== 1'b1; t++) cyc(1);
    chk("reset_not_early", t > 45, 1'b1);
    chk("reset_released", rs_n, 1'b1);
    chk("wd_mode_init", mode === SSRW_WD_INIT, 1'b1);
    for (; t < 440 && wd_n !== 1'b0; t++) cyc(1);
    chk("wd_init_not_early", t > 390, 1'b1);
    chk("wd_expired", wd_n, 1'b0);
    @(posedge clk) kick_en <= 1'b1;
    // Host toggles once per 32 cycles; allow one period plus sync
    cyc(40);
    chk("wd_cleared", wd_n, 1'b1);
    chk("wd_mode_norm", mode === SSRW_WD_NORM, 1'b1);
    cyc(200);
    chk("wd_kicked_stays", wd_n, 1'b1);
    @(posedge clk) kick_en <= 1'b0;
    for (t = 0; t < 120 && wd_n !== 1'b0; t++) cyc(1);
    chk("wd_norm_window", t > 60 && t < 115, 1'b1);
    @(posedge clk) kick_en <= 1'b1;
  endtask
  task automatic t_rst(bit by_mr);
    @(posedge clk) if (by_mr) mr_req <= 1'b1; else uv <= 6'h04;
    cyc(20);
    chk("reset_low", rs_n, 1'b0);
    @(posedge clk) if (by_mr) mr_req <= 1'b0; else uv <= 6'h00;
    cyc(40);
    chk("reset_held", rs_n, 1'b0);
    for (t = 0; t < 30 && rs_n !== 1'b1; t++) cyc(1);
    chk("reset_after_delay", rs_n, 1'b1);
  endtask
  task automatic t_misc;
    @(posedge clk) mr_req <= 1'b1;
    cyc(2);
    @(posedge clk) mr_req <= 1'b0;
    cyc(10);
    chk("mr_glitch", rs_n, 1'b1);
    @(posedge clk) en <= 6'h3e;
    uv <= 6'h01;
    cyc(10);
    chk("disabled_rail", rs_n, 1'b1);
    @(posedge clk) uv <= 6'h00;
    en <= 6'h3f;
    ov <= 6'h20;
    cyc(5);
    chk("ov_low", ov_n, 1'b0);
    @(posedge clk) ov <= 6'h00;
    cyc(6);
    chk("ov_held", ov_n, 1'b0);
    cyc(12);
    chk("ov_released", ov_n, 1'b1);
  endtask
  task automatic t_margin;
    @(posedge clk) mg_n <= 1'b0;
    cyc(4);
    @(posedge clk) {uv, ov, mr_req, kick_en} <= {6'h01, 6'h01, 2'b10};
    cyc(150);
    chk("margin_reset", rs_n, 1'b1);
    chk("margin_ov", ov_n, 1'b1);
    chk("margin_wd", wd_n, 1'b1);
    @(posedge clk) {uv, ov, mr_req, kick_en} <= {6'h00, 6'h00, 2'b01};
    cyc(4);
    @(posedge clk) mg_n <= 1'b1;
    cyc(10);
    chk("margin_over_mr", rs_n, 1'b1);
  endtask
  initial begin
    #50000;
    fails++;
    end_of_test;
  end
  initial begin
    cyc(20);
    @(posedge clk) rst_n <= 1'b1;
    t_power;
    t_rst(1'b0);
    t_rst(1'b1);
    t_misc;
    t_margin;
    end_of_test;
  end
endmodule
